// ---- design/furl_pkg.sv ----
// What this block does
// - Start record type code is 0x00
// - Length counts bytes after device type
// - Start layout: type,len,dev,res,addresses,res,sum
// - Erase bounds are 32-bit little-endian
// - Start checksum covers length onward
// - Data record is 7+payload, max 64
// - Data record type code is 0x0f
// - Data length counts bytes after address
// - Payload written from little-endian load address
// - Payload holds 1 to 57 bytes
// - Data checksum covers length, address, payload
// - End record: 4 bytes, type 0xf0
// - Response record type is 0xFF
// - Response type ACK, retry NAK, end NAK
// - Response length counts bytes after type
// - Start response field reports backup state
package furl_pkg;
   localparam logic [7:0] REC_START = 8'h00;
   localparam logic [7:0] REC_DATA = 8'h0f;
   localparam logic [7:0] REC_END = 8'hf0;
   localparam logic [7:0] RESP_REC = 8'hff;
   localparam logic [7:0] RESP_ACK = 8'h00;
   localparam logic [7:0] RESP_NAK_RETRY = 8'h0f;
   localparam logic [7:0] RESP_NAK_END = 8'hf0;
   localparam logic [7:0] FIELD_BACKUP_ON = 8'hb0;
   localparam logic [7:0] FIELD_BACKUP_OFF = 8'hb1;
   localparam logic [7:0] FIELD_WRITING = 8'h03;
   localparam logic [7:0] FIELD_PARAM_ERR = 8'he4;
   localparam logic [7:0] FIELD_NONE = 8'h00;
   localparam logic [7:0] RESP_LEN = 8'h02;
   localparam logic [2:0] RESP_BYTES = 3'h5;
   localparam logic [7:0] START_LEN = 8'h0b;
   localparam logic [7:0] END_LEN = 8'h01;
   localparam logic [8:0] START_BODY = 9'h00c;
   localparam logic [8:0] END_BODY = 9'h002;
   localparam logic [8:0] DATA_ADDR_BYTES = 9'h004;
   localparam logic [8:0] POS_ERS_START = 9'h002;
   localparam logic [8:0] POS_ERS_END = 9'h006;
   localparam logic [8:0] POS_ERS_LAST = 9'h009;
   localparam int DATA_OVERHEAD = 7;
   localparam int REC_MAX_BYTES = 64;
   localparam int DATA_MAX_PAYLOAD = 57;
   localparam int FIFO_DEPTH = 4;

   typedef struct packed {
      logic [31:0] addr;
      logic [7:0] data;
   } furl_flash_word_t;

   typedef struct packed {
      logic [31:0] start;
      logic [31:0] stop;
   } furl_erase_range_t;

   typedef enum logic [5:0] {
      ST_TYPE = 6'b000001,
      ST_LEN = 6'b000010,
      ST_BODY = 6'b000100,
      ST_DRAIN = 6'b001000,
      ST_RESP = 6'b010000,
      ST_WAIT = 6'b100000
   } furl_state_t;

   typedef enum logic [1:0] {
      K_START = 2'h0,
      K_DATA = 2'h1,
      K_END = 2'h2
   } furl_kind_t;
endpackage : furl_pkg

// ---- design/furl_fifo.sv ----
module furl_fifo
#(
   parameter int WIDTH = 40,
   parameter int DEPTH = 4
)
(
   input wire logic clk_i,
   input wire logic srst_i,
   input wire logic in_valid_i,
   input wire logic [WIDTH-1:0] in_data_i,
   output logic in_ready_o,
   output logic out_valid_o,
   output logic [WIDTH-1:0] out_data_o,
   input wire logic out_ready_i
);
   localparam int AW = $clog2(DEPTH);
   localparam logic [AW:0] FULL = (AW+1)'(DEPTH);

   generate
      if (DEPTH < 2 || (DEPTH & (DEPTH - 1)) != 0)
      begin : g_bad_depth
         $error("fifo depth must be a power of two, at least 2");
      end
   endgenerate

   logic [WIDTH-1:0] mem_ff [DEPTH];
   logic [AW-1:0] wr_ptr_ff, nxt_wr_ptr, rd_ptr_ff, nxt_rd_ptr;
   logic [AW:0] count_ff, nxt_count;
   logic push, pop;

   assign in_ready_o = count_ff != FULL;
   assign out_valid_o = count_ff != '0;
   assign out_data_o = mem_ff[rd_ptr_ff];

   always_comb
   begin
      push = in_valid_i && in_ready_o;
      pop = out_valid_o && out_ready_i;
      nxt_wr_ptr = push ? wr_ptr_ff + 1'b1 : wr_ptr_ff;
      nxt_rd_ptr = pop ? rd_ptr_ff + 1'b1 : rd_ptr_ff;
      nxt_count = count_ff + (AW+1)'(push) - (AW+1)'(pop);
   end

   always_ff @(posedge clk_i)
   begin
      if (srst_i)
      begin
         wr_ptr_ff <= '0;
         rd_ptr_ff <= '0;
         count_ff <= '0;
      end
      else
      begin
         wr_ptr_ff <= nxt_wr_ptr;
         rd_ptr_ff <= nxt_rd_ptr;
         count_ff <= nxt_count;
      end
   end

   always_ff @(posedge clk_i)
   begin
      if (push)
      begin
         mem_ff[wr_ptr_ff] <= in_data_i;
      end
   end
endmodule : furl_fifo

// ---- design/furl_resp_tx.sv ----
module furl_resp_tx
(
   input wire logic clk_i,
   input wire logic srst_i,
   input wire logic start_i,
   input wire logic [7:0] type_i,
   input wire logic [7:0] field_i,
   input wire logic tx_ready_i,
   output logic [7:0] tx_data_o,
   output logic tx_valid_o
);
   import furl_pkg::*;

   logic [2:0] idx_ff, nxt_idx;
   logic [7:0] type_ff, nxt_type, field_ff, nxt_field, data_ff, nxt_data;
   logic valid_ff, nxt_valid;

   assign tx_data_o = data_ff;
   assign tx_valid_o = valid_ff;

   always_comb
   begin
      nxt_idx = idx_ff;
      nxt_type = type_ff;
      nxt_field = field_ff;
      nxt_data = data_ff;
      nxt_valid = valid_ff;
      if (!valid_ff)
      begin
         if (start_i)
         begin
            nxt_valid = 1'b1;
            nxt_idx = '0;
            nxt_type = type_i;
            nxt_field = field_i;
            nxt_data = RESP_REC;
         end
      end
      else if (tx_ready_i)
      begin
         nxt_idx = idx_ff + 3'h1;
         unique case (nxt_idx)
            3'h1: nxt_data = RESP_LEN;
            3'h2: nxt_data = type_ff;
            3'h3: nxt_data = field_ff;
            default: nxt_data = 8'(RESP_LEN + type_ff + field_ff);
         endcase
         if (idx_ff == RESP_BYTES - 3'h1)
         begin
            nxt_valid = 1'b0;
         end
      end
   end

   always_ff @(posedge clk_i)
   begin
      if (srst_i)
      begin
         idx_ff <= '0;
         type_ff <= '0;
         field_ff <= '0;
         data_ff <= '0;
         valid_ff <= 1'b0;
      end
      else
      begin
         idx_ff <= nxt_idx;
         type_ff <= nxt_type;
         field_ff <= nxt_field;
         data_ff <= nxt_data;
         valid_ff <= nxt_valid;
      end
   end

   property p_resp_head;
      @(posedge clk_i) disable iff (srst_i)
      start_i && !valid_ff |=> valid_ff && data_ff == RESP_REC && idx_ff == 3'h0;
   endproperty
   a_resp_head: assert property (p_resp_head) else $error("response does not open with 0xff");

   property p_resp_len;
      @(posedge clk_i) disable iff (srst_i)
      valid_ff && tx_ready_i && idx_ff == 3'h0 |=> data_ff == RESP_LEN;
   endproperty
   a_resp_len: assert property (p_resp_len) else $error("response length byte wrong");

   property p_resp_type;
      @(posedge clk_i) disable iff (srst_i)
      valid_ff && idx_ff == 3'h2 |->
         data_ff == RESP_ACK || data_ff == RESP_NAK_RETRY || data_ff == RESP_NAK_END;
   endproperty
   a_resp_type: assert property (p_resp_type) else $error("illegal response type");

   property p_resp_sum;
      @(posedge clk_i) disable iff (srst_i)
      valid_ff && tx_ready_i && idx_ff == 3'h3 |=>
         data_ff == 8'($past(data_ff) + $past(type_ff) + RESP_LEN) ##1 (!valid_ff || !$past(tx_ready_i));
   endproperty
   a_resp_sum: assert property (p_resp_sum) else $error("response checksum wrong");
endmodule : furl_resp_tx

// ---- design/furl_top.sv ----
module furl_top
#(
   parameter int MAX_PAYLOAD = furl_pkg::DATA_MAX_PAYLOAD,
   parameter int DEPTH = furl_pkg::FIFO_DEPTH
)
(
   input wire logic CORE_CLK_I,
   input wire logic SRST_I,
   input wire logic [7:0] RX_DATA_I,
   input wire logic RX_VALID_I,
   output logic RX_READY_O,
   output logic [7:0] TX_DATA_O,
   output logic TX_VALID_O,
   input wire logic TX_READY_I,
   input wire logic BACKUP_EN_I,
   output logic ERASE_REQ_O,
   output furl_pkg::furl_erase_range_t ERASE_RANGE_O,
   output logic FLASH_WR_VALID_O,
   output furl_pkg::furl_flash_word_t FLASH_WR_O,
   input wire logic FLASH_WR_READY_I,
   output logic SESSION_O
);
   import furl_pkg::*;

   localparam int WW = $bits(furl_flash_word_t);
   localparam logic [7:0] LEN_MIN = 8'h02;
   localparam logic [7:0] LEN_MAX = 8'(MAX_PAYLOAD + 1);

   generate
      if (MAX_PAYLOAD < 1 || MAX_PAYLOAD > REC_MAX_BYTES - DATA_OVERHEAD)
      begin : g_bad_payload
         $error("payload size cannot exceed the record limit");
      end
   endgenerate

   furl_state_t state_ff, nxt_state;
   furl_kind_t kind_ff, nxt_kind;
   logic [7:0] len_ff, nxt_len, sum_ff, nxt_sum;
   logic [8:0] remain_ff, nxt_remain, pos_ff, nxt_pos;
   logic [31:0] addr_ff, nxt_addr, end_ff, nxt_end;
   logic [5:0] pay_cnt_ff, nxt_pay_cnt, drain_ff, nxt_drain;
   logic [7:0] resp_type_ff, nxt_resp_type, resp_field_ff, nxt_resp_field;
   logic session_ff, nxt_session, rx_ready_ff, nxt_rx_ready;
   logic erase_req_ff, nxt_erase_req;
   furl_erase_range_t range_ff, nxt_range;
   logic [7:0] pay_mem_ff [MAX_PAYLOAD];
   logic pay_we;
   logic [5:0] pay_idx;
   logic [8:0] rel;
   logic rx_take, resp_start, push, fifo_in_ready, fifo_out_valid, fifo_out_ready;
   furl_flash_word_t push_word, fifo_out_word, wr_word_ff, nxt_wr_word;
   logic wr_valid_ff, nxt_wr_valid;

   assign RX_READY_O = rx_ready_ff;
   assign ERASE_REQ_O = erase_req_ff;
   assign ERASE_RANGE_O = range_ff;
   assign FLASH_WR_VALID_O = wr_valid_ff;
   assign FLASH_WR_O = wr_word_ff;
   assign SESSION_O = session_ff;

   assign rx_take = RX_VALID_I && rx_ready_ff;
   assign push_word = '{addr: addr_ff + 32'(drain_ff), data: pay_mem_ff[drain_ff]};

   always_comb
   begin
      nxt_state = state_ff;
      nxt_kind = kind_ff;
      nxt_len = len_ff;
      nxt_sum = sum_ff;
      nxt_remain = remain_ff;
      nxt_pos = pos_ff;
      nxt_addr = addr_ff;
      nxt_end = end_ff;
      nxt_pay_cnt = pay_cnt_ff;
      nxt_drain = drain_ff;
      nxt_resp_type = resp_type_ff;
      nxt_resp_field = resp_field_ff;
      nxt_session = session_ff;
      nxt_erase_req = 1'b0;
      nxt_range = range_ff;
      resp_start = 1'b0;
      push = 1'b0;
      pay_we = 1'b0;
      pay_idx = '0;
      rel = '0;
      unique case (state_ff)
         ST_TYPE:
         begin
            if (rx_take)
            begin
               nxt_pos = '0;
               nxt_state = ST_LEN;
               if (RX_DATA_I == REC_START)
               begin
                  nxt_kind = K_START;
               end
               else if (RX_DATA_I == REC_DATA)
               begin
                  nxt_kind = K_DATA;
               end
               else if (RX_DATA_I == REC_END)
               begin
                  nxt_kind = K_END;
               end
               else
               begin
                  nxt_resp_type = RESP_NAK_RETRY;
                  nxt_resp_field = FIELD_NONE;
                  nxt_state = ST_RESP;
               end
            end
         end
         ST_LEN:
         begin
            if (rx_take)
            begin
               nxt_len = RX_DATA_I;
               nxt_sum = RX_DATA_I;
               unique case (kind_ff)
                  K_START: nxt_remain = START_BODY;
                  K_END: nxt_remain = END_BODY;
                  default: nxt_remain = DATA_ADDR_BYTES + {1'b0, RX_DATA_I};
               endcase
               nxt_state = ST_BODY;
            end
         end
         ST_BODY:
         begin
            if (rx_take)
            begin
               nxt_pos = pos_ff + 9'h001;
               nxt_remain = remain_ff - 9'h001;
               if (remain_ff != 9'h001)
               begin
                  nxt_sum = 8'(sum_ff + RX_DATA_I);
                  if (kind_ff == K_START && pos_ff >= POS_ERS_START && pos_ff < POS_ERS_END)
                  begin
                     rel = pos_ff - POS_ERS_START;
                     nxt_addr[{rel[1:0], 3'h0} +: 8] = RX_DATA_I;
                  end
                  else if (kind_ff == K_START && pos_ff >= POS_ERS_END && pos_ff <= POS_ERS_LAST)
                  begin
                     rel = pos_ff - POS_ERS_END;
                     nxt_end[{rel[1:0], 3'h0} +: 8] = RX_DATA_I;
                  end
                  else if (kind_ff == K_DATA && pos_ff < DATA_ADDR_BYTES)
                  begin
                     nxt_addr[{pos_ff[1:0], 3'h0} +: 8] = RX_DATA_I;
                  end
                  else if (kind_ff == K_DATA && pos_ff < DATA_ADDR_BYTES + 9'(MAX_PAYLOAD))
                  begin
                     rel = pos_ff - DATA_ADDR_BYTES;
                     pay_we = 1'b1;
                     pay_idx = rel[5:0];
                  end
               end
               else
               begin
                  nxt_state = ST_RESP;
                  nxt_resp_type = RESP_NAK_END;
                  nxt_resp_field = FIELD_PARAM_ERR;
                  if (RX_DATA_I != sum_ff)
                  begin
                     nxt_resp_type = RESP_NAK_RETRY;
                     nxt_resp_field = FIELD_NONE;
                  end
                  else if (kind_ff == K_START && len_ff == START_LEN)
                  begin
                     nxt_erase_req = 1'b1;
                     nxt_range = '{start: addr_ff, stop: end_ff};
                     nxt_session = 1'b1;
                     nxt_resp_type = RESP_ACK;
                     nxt_resp_field = BACKUP_EN_I ? FIELD_BACKUP_ON : FIELD_BACKUP_OFF;
                  end
                  else if (kind_ff == K_DATA && session_ff && len_ff >= LEN_MIN && len_ff <= LEN_MAX)
                  begin
                     nxt_pay_cnt = 6'(len_ff - 8'h01);
                     nxt_drain = '0;
                     nxt_state = ST_DRAIN;
                  end
                  else if (kind_ff == K_END && len_ff == END_LEN)
                  begin
                     nxt_session = 1'b0;
                     nxt_resp_type = RESP_ACK;
                     nxt_resp_field = FIELD_NONE;
                  end
               end
            end
         end
         ST_DRAIN:
         begin
            push = 1'b1;
            if (fifo_in_ready)
            begin
               nxt_drain = drain_ff + 6'h01;
               if (drain_ff == pay_cnt_ff - 6'h01)
               begin
                  nxt_resp_type = RESP_ACK;
                  nxt_resp_field = FIELD_WRITING;
                  nxt_state = ST_RESP;
               end
            end
         end
         ST_RESP:
         begin
            resp_start = 1'b1;
            nxt_state = ST_WAIT;
         end
         ST_WAIT:
         begin
            if (!TX_VALID_O)
            begin
               nxt_state = ST_TYPE;
            end
         end
      endcase
      // Ready only while a record is being taken in; stop-and-wait host
      nxt_rx_ready = nxt_state == ST_TYPE || nxt_state == ST_LEN || nxt_state == ST_BODY;
   end

   always_comb
   begin
      fifo_out_ready = !wr_valid_ff || FLASH_WR_READY_I;
      nxt_wr_valid = wr_valid_ff;
      nxt_wr_word = wr_word_ff;
      if (fifo_out_ready)
      begin
         nxt_wr_valid = fifo_out_valid;
         nxt_wr_word = fifo_out_word;
      end
   end

   always_ff @(posedge CORE_CLK_I)
   begin
      if (SRST_I)
      begin
         state_ff <= ST_TYPE;
         kind_ff <= K_START;
         len_ff <= '0;
         sum_ff <= '0;
         remain_ff <= '0;
         pos_ff <= '0;
         addr_ff <= '0;
         end_ff <= '0;
         pay_cnt_ff <= '0;
         drain_ff <= '0;
         resp_type_ff <= RESP_ACK;
         resp_field_ff <= FIELD_NONE;
         session_ff <= 1'b0;
         rx_ready_ff <= 1'b0;
         erase_req_ff <= 1'b0;
         range_ff <= '0;
         wr_valid_ff <= 1'b0;
         wr_word_ff <= '0;
      end
      else
      begin
         state_ff <= nxt_state;
         kind_ff <= nxt_kind;
         len_ff <= nxt_len;
         sum_ff <= nxt_sum;
         remain_ff <= nxt_remain;
         pos_ff <= nxt_pos;
         addr_ff <= nxt_addr;
         end_ff <= nxt_end;
         pay_cnt_ff <= nxt_pay_cnt;
         drain_ff <= nxt_drain;
         resp_type_ff <= nxt_resp_type;
         resp_field_ff <= nxt_resp_field;
         session_ff <= nxt_session;
         rx_ready_ff <= nxt_rx_ready;
         erase_req_ff <= nxt_erase_req;
         range_ff <= nxt_range;
         wr_valid_ff <= nxt_wr_valid;
         wr_word_ff <= nxt_wr_word;
      end
   end

   always_ff @(posedge CORE_CLK_I)
   begin
      if (pay_we)
      begin
         pay_mem_ff[pay_idx] <= RX_DATA_I;
      end
   end

   furl_fifo #(.WIDTH(WW), .DEPTH(DEPTH)) u_fifo (
      .clk_i(CORE_CLK_I),
      .srst_i(SRST_I),
      .in_valid_i(push),
      .in_data_i(push_word),
      .in_ready_o(fifo_in_ready),
      .out_valid_o(fifo_out_valid),
      .out_data_o(fifo_out_word),
      .out_ready_i(fifo_out_ready)
   );

   furl_resp_tx u_resp (
      .clk_i(CORE_CLK_I),
      .srst_i(SRST_I),
      .start_i(resp_start),
      .type_i(resp_type_ff),
      .field_i(resp_field_ff),
      .tx_ready_i(TX_READY_I),
      .tx_data_o(TX_DATA_O),
      .tx_valid_o(TX_VALID_O)
   );

   property p_start_code;
      @(posedge CORE_CLK_I) disable iff (SRST_I)
      state_ff == ST_TYPE && rx_take && RX_DATA_I == REC_START |=> state_ff == ST_LEN && kind_ff == K_START;
   endproperty
   a_start_code: assert property (p_start_code) else $error("start code not decoded");

   property p_data_code;
      @(posedge CORE_CLK_I) disable iff (SRST_I)
      state_ff == ST_TYPE && rx_take && RX_DATA_I == REC_DATA |=> state_ff == ST_LEN && kind_ff == K_DATA;
   endproperty
   a_data_code: assert property (p_data_code) else $error("data code not decoded");

   property p_end_code;
      @(posedge CORE_CLK_I) disable iff (SRST_I)
      state_ff == ST_TYPE && rx_take && RX_DATA_I == REC_END |=>
         kind_ff == K_END ##1 (state_ff == ST_LEN || remain_ff == END_BODY);
   endproperty
   a_end_code: assert property (p_end_code) else $error("end record not decoded");

   property p_bad_sum;
      @(posedge CORE_CLK_I) disable iff (SRST_I)
      state_ff == ST_BODY && rx_take && remain_ff == 9'h001 && RX_DATA_I != sum_ff |=>
         state_ff == ST_RESP && resp_type_ff == RESP_NAK_RETRY ##1 state_ff == ST_WAIT;
   endproperty
   a_bad_sum: assert property (p_bad_sum) else $error("bad checksum not answered with retry");

   property p_erase_sum;
      @(posedge CORE_CLK_I) disable iff (SRST_I)
      $rose(erase_req_ff) |-> $past(RX_DATA_I) == $past(sum_ff) && $past(len_ff) == START_LEN;
   endproperty
   a_erase_sum: assert property (p_erase_sum) else $error("erase without a valid start record");

   property p_backup_field;
      @(posedge CORE_CLK_I) disable iff (SRST_I)
      erase_req_ff |-> resp_field_ff == ($past(BACKUP_EN_I) ? FIELD_BACKUP_ON : FIELD_BACKUP_OFF);
   endproperty
   a_backup_field: assert property (p_backup_field) else $error("start answer has wrong backup code");

   property p_payload_bounds;
      @(posedge CORE_CLK_I) disable iff (SRST_I)
      state_ff == ST_DRAIN |-> pay_cnt_ff >= 6'h01 && 32'(pay_cnt_ff) <= MAX_PAYLOAD && session_ff;
   endproperty
   a_payload_bounds: assert property (p_payload_bounds) else $error("payload count out of range");

   property p_load_addr;
      @(posedge CORE_CLK_I) disable iff (SRST_I)
      $rose(state_ff == ST_DRAIN) |-> push_word.addr == addr_ff && push_word.data == pay_mem_ff[0];
   endproperty
   a_load_addr: assert property (p_load_addr) else $error("first payload byte not at load address");
endmodule : furl_top

// ---- sim/furl_host.sv ----
module furl_host
(
   input wire logic clk_i,
   input wire logic slow_i,
   input wire logic rx_ready_i,
   output logic [7:0] rx_data_o,
   output logic rx_valid_o,
   input wire logic [7:0] tx_data_i,
   input wire logic tx_valid_i,
   output logic tx_ready_o
);
   timeunit 1ns;
   timeprecision 1ps;
   initial
   begin
      {rx_data_o, rx_valid_o, tx_ready_o} = 10'h000;
   end
   // Next record only after the whole response
   task automatic xfer(input logic [7:0] rec[$], output logic [7:0] rsp[$]);
      int i;
      int t;
      i = 0;
      t = 0;
      rsp = {};
      while (i < rec.size() && tx_valid_i !== 1'b1 && t < 3000)
      begin
         rx_valid_o <= 1'b1;
         rx_data_o <= rec[i];
         @(posedge clk_i);
         t++;
         i += rx_ready_i === 1'b1;
      end
      rx_valid_o <= 1'b0;
      rx_data_o <= ~rx_data_o;
      // First wait plus three retries before reception counts as failed
      for (int n = 0; n < 4 && rsp.size() < 5; n++)
      begin
         t = 0;
         while (rsp.size() < 5 && t < 750)
         begin
            tx_ready_o <= slow_i ? ~tx_ready_o : 1'b1;
            @(posedge clk_i);
            t++;
            if (tx_valid_i === 1'b1 && tx_ready_o === 1'b1)
               rsp.push_back(tx_data_i);
         end
      end
      tx_ready_o <= 1'b0;
   endtask : xfer
endmodule : furl_host

// ---- sim/furl_top_tb.sv ----
module furl_top_tb;
   timeunit 1ns;
   timeprecision 1ps;
   import furl_pkg::*;
   typedef logic [7:0] furl_bq_t[$];
   logic clk, srst, rx_valid, rx_ready, tx_valid, tx_ready, backup, erq, fl_valid, fl_rdy, sess_o, slow, sess;
   logic [7:0] rx_data, tx_data;
   logic [31:0] seed = 32'h0000003b;
   logic [63:0] exp_rng;
   furl_erase_range_t rng;
   furl_flash_word_t fl_word;
   furl_flash_word_t exp_fl[$];
   int n_fail, checks, n_erase;
   furl_top #(.MAX_PAYLOAD(DATA_MAX_PAYLOAD), .DEPTH(FIFO_DEPTH)) dut
   (
      .CORE_CLK_I(clk),
      .SRST_I(srst),
      .RX_DATA_I(rx_data),
      .RX_VALID_I(rx_valid),
      .RX_READY_O(rx_ready),
      .TX_DATA_O(tx_data),
      .TX_VALID_O(tx_valid),
      .TX_READY_I(tx_ready),
      .BACKUP_EN_I(backup),
      .ERASE_REQ_O(erq),
      .ERASE_RANGE_O(rng),
      .FLASH_WR_VALID_O(fl_valid),
      .FLASH_WR_O(fl_word),
      .FLASH_WR_READY_I(fl_rdy),
      .SESSION_O(sess_o)
   );
   furl_host host
   (
      .clk_i(clk),
      .slow_i(slow),
      .rx_ready_i(rx_ready),
      .rx_data_o(rx_data),
      .rx_valid_o(rx_valid),
      .tx_data_i(tx_data),
      .tx_valid_i(tx_valid),
      .tx_ready_o(tx_ready)
   );
   initial
   begin
      clk = 1'b0;
      forever #10 clk = ~clk;
   end
   function automatic logic [31:0] rnd();
      seed ^= seed << 13;
      seed ^= seed >> 17;
      seed ^= seed << 5;
      return seed;
   endfunction : rnd
   task automatic chk(input logic [63:0] got, input logic [63:0] exp);
      checks++;
      if (got !== exp)
      begin
         n_fail++;
         $display("MISMATCH at %0t: got %0h expected %0h", $time, got, exp);
      end
   endtask : chk
   task automatic complete_run();
      $display("Counts: %0d checks, %0d mismatches", checks, n_fail);
      if (n_fail == 0 && checks > 0)
         $display("All checks passed");
      else
         $display("Checks failed");
      $finish;
   endtask : complete_run
   function automatic furl_bq_t mk(logic [7:0] t, furl_bq_t b);
      logic [7:0] s;
      s = 8'h00;
      foreach (b[i])
         s += b[i];
      return {t, b, s};
   endfunction : mk
   // Reference answer; also queues the expected erase range and flash words
   function automatic logic [15:0] model(furl_bq_t r);
      logic [7:0] s;
      int n;
      n = r.size();
      s = 8'h00;
      for (int i = 1; i < n - 1; i++)
         s += r[i];
      if (r[0] != REC_START && r[0] != REC_DATA && r[0] != REC_END)
         return {RESP_NAK_RETRY, FIELD_NONE};
      if (s != r[n - 1])
         return {RESP_NAK_RETRY, FIELD_NONE};
      if ((r[0] == REC_START && r[1] != START_LEN) || (r[0] == REC_END && r[1] != END_LEN)
          || (r[0] == REC_DATA && (r[1] < 8'h02 || r[1] > 8'h3a || !sess)))
         return {RESP_NAK_END, FIELD_PARAM_ERR};
      if (r[0] == REC_START)
      begin
         sess = 1'b1;
         exp_rng = {r[7], r[6], r[5], r[4], r[11], r[10], r[9], r[8]};
         return {RESP_ACK, backup ? FIELD_BACKUP_ON : FIELD_BACKUP_OFF};
      end
      if (r[0] == REC_END)
      begin
         sess = 1'b0;
         return {RESP_ACK, FIELD_NONE};
      end
      for (int i = 0; i < r[1] - 1; i++)
         exp_fl.push_back({{r[5], r[4], r[3], r[2]} + 32'(i), r[6 + i]});
      return {RESP_ACK, FIELD_WRITING};
   endfunction : model
   task automatic run(input string nm, input furl_bq_t r);
      logic [15:0] e;
      logic [7:0] rsp[$];
      logic [7:0] x[$];
      int ne;
      ne = n_erase;
      e = model(r);
      x = {RESP_REC, RESP_LEN, e[15:8], e[7:0], 8'(RESP_LEN + e[15:8] + e[7:0])};
      host.xfer(r, rsp);
      chk(64'(rsp.size()), 64'h5);
      foreach (x[i])
         chk(rsp[i], x[i]);
      repeat (2) @(posedge clk);
      chk(rx_ready, 1'b1);
      chk(64'(n_erase - ne), (r[0] == REC_START && e[15:8] == RESP_ACK) ? 64'h1 : 64'h0);
      chk(sess_o, sess);
      $display("test %s done", nm);
   endtask : run
   // Flash side stalls often so the FIFO fills
   always @(posedge clk)
   begin
      fl_rdy <= rnd() % 8 < 3;
      if (erq === 1'b1)
      begin
         n_erase++;
         chk(rng, exp_rng);
      end
      if (fl_valid === 1'b1 && fl_rdy === 1'b1)
      begin
         if (exp_fl.size() == 0)
            chk(1'b1, 1'b0);
         else
            chk(fl_word, exp_fl.pop_front());
      end
   end
   initial
   begin
      repeat (20000) @(posedge clk);
      n_fail++;
      complete_run();
   end
   initial
   begin
      furl_bq_t b;
      furl_bq_t sb;
      furl_bq_t r;
      logic [31:0] a;
      int n;
      {srst, backup, slow, sess} = 4'hc;
      repeat (3) @(posedge clk);
      srst <= 1'b0;
      chk({tx_valid, erq, fl_valid, sess_o, rx_ready}, 5'h00);
      @(posedge clk);
      run("nosession", mk(REC_DATA, {8'h02, 8'h00, 8'h10, 8'h00, 8'h00, 8'h5a}));
      sb = {START_LEN, 8'h00, 8'h00, 8'h00, 8'h80, 8'h00, 8'h00, 8'hff, 8'hff, 8'h01, 8'h00, 8'h00};
      r = mk(REC_START, sb);
      r[13] ^= 8'h01;
      run("start_badsum", r);
      run("start", mk(REC_START, sb));
      run("unknown", {8'h55, 8'h01, 8'h00, 8'h01});
      for (int k = 0; k < 6; k++)
      begin
         n = k == 0 ? 1 : k == 1 ? 57 : 1 + rnd() % 57;
         // Whole address space counts as flash, so no address stops the host
         a = rnd();
         slow <= k[0];
         b = {8'(n + 1), a[7:0], a[15:8], a[23:16], a[31:24]};
         repeat (n) b.push_back(8'(rnd()));
         run("data", mk(REC_DATA, b));
      end
      r = mk(REC_DATA, b);
      r[r.size() - 1] ^= 8'h80;
      run("data_badsum", r);
      b = {8'h3b, 8'h00, 8'h20, 8'h00, 8'h00};
      repeat (58) b.push_back(8'h11);
      run("data_long", mk(REC_DATA, b));
      // After an error end the host opens a fresh session
      backup <= 1'b0;
      @(posedge clk);
      run("restart", mk(REC_START, sb));
      run("end_badlen", mk(REC_END, {8'h02, 8'h00}));
      run("reopen", mk(REC_START, sb));
      run("end", mk(REC_END, {END_LEN, 8'h00}));
      n = 0;
      while (exp_fl.size() > 0 && n < 2000)
      begin
         @(posedge clk);
         n++;
      end
      chk(64'(exp_fl.size()), 64'h0);
      complete_run();
   end
endmodule : furl_top_tb
